//--- core/ppu_defs.vh
`ifndef PPU_DEFS_VH
`define PPU_DEFS_VH

`define PPU_A_DATA 8'h1c
`define PPU_A_CMD 8'h1d
`define PPU_B_DATA 8'h1e
`define PPU_B_CMD 8'h1f

`define PPU_MODE_OUT 2'h0
`define PPU_MODE_IN 2'h1
`define PPU_MODE_BIDIR 2'h2
`define PPU_MODE_BIT 2'h3

`define PPU_CODE_MODE 4'hf
`define PPU_CODE_DIS 4'h3
`define PPU_CODE_ICTL 2'h1

`define PPU_BIT_ENA 7
`define PPU_BIT_ANDF 0
`define PPU_BIT_LVL 1
`define PPU_BIT_MASKF 4

`define PPU_EXP_NONE 2'h0
`define PPU_EXP_DIR 2'h1
`define PPU_EXP_MASK 2'h2

`define PPU_RST_MODE 2'h1
`define PPU_RST_BYTE 8'hff
`define PPU_RST_VEC 8'h00
`define PPU_UNMAPPED 8'h00

`endif

//--- core/ppu_top.v
`timescale 1ns/1ps
`default_nettype none
`include "ppu_defs.vh"

module ppu_top #(
  parameter BUF_AW = 1
) (
  input wire CLOCK,
  input wire SYS_RST,
  input wire [7:0] IO_ADDR,
  input wire [7:0] IO_WDATA,
  input wire IO_WR,
  input wire IO_RD,
  output reg [7:0] IO_RDATA,
  output wire IO_WR_READY,
  output wire [1:0] INT_REQ,
  input wire INT_ACK,
  output reg [7:0] INT_VECTOR,
  input wire [15:0] PORT_IN,
  output wire [15:0] PORT_OUT,
  output wire [15:0] PORT_OE_N,
  output wire [1:0] READY,
  input wire [1:0] PERIPHERAL_STROBE_IN_N
);

  localparam DEPTH = 1 << BUF_AW;

  wire [15:0] rd_val;
  wire [15:0] vec_all;
  wire [1:0] wr_ready;
  wire [1:0] ack_p;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt acknowledge: port A has priority over port B

  assign ack_p[0] = INT_ACK & INT_REQ[0];
  assign ack_p[1] = INT_ACK & ~INT_REQ[0] & INT_REQ[1];

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      INT_VECTOR <= `PPU_RST_VEC;
    end else if (INT_ACK) begin
      INT_VECTOR <= INT_REQ[0] ? vec_all[7:0] : vec_all[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      IO_RDATA <= `PPU_UNMAPPED;
    end else if (IO_RD) begin
      case (IO_ADDR)
        `PPU_A_DATA: IO_RDATA <= rd_val[7:0];
        `PPU_B_DATA: IO_RDATA <= rd_val[15:8];
        default: IO_RDATA <= `PPU_UNMAPPED;
      endcase
    end
  end

  // Write-only command registers are always ready; data writes wait on a full buffer only in output and bidirectional modes
  assign IO_WR_READY = (IO_ADDR == `PPU_A_DATA) ? wr_ready[0] :
                       (IO_ADDR == `PPU_B_DATA) ? wr_ready[1] : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port logic

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      localparam [7:0] DATA_ADDR = (p == 0) ? `PPU_A_DATA : `PPU_B_DATA;
      localparam [7:0] CMD_ADDR = (p == 0) ? `PPU_A_CMD : `PPU_B_CMD;
      // Cut to the counter's width on purpose; depth always fits in BUF_AW+1 bits
      localparam [BUF_AW:0] FULL_CNT = DEPTH[BUF_AW:0];

      reg [1:0] mode_q;
      reg [7:0] dir_q;
      reg [7:0] mask_q;
      reg [7:0] vec_q;
      reg [7:0] out_q;
      reg [1:0] expect_q;
      reg ie_q;
      reg andf_q;
      reg lvl_q;
      reg pend_q;
      reg [7:0] pin_s1_q;
      reg [7:0] pin_s2_q;
      reg [7:0] pin_s3_q;
      reg [7:0] pin_f_q;
      reg stb_s1_q;
      reg stb_s2_q;
      reg stb_s3_q;
      reg stb_f_q;
      reg [7:0] fmem [0:DEPTH-1];
      reg [BUF_AW-1:0] wp_q;
      reg [BUF_AW-1:0] rp_q;
      reg [BUF_AW:0] cnt_q;

      wire cmd_wr = IO_WR && (IO_ADDR == CMD_ADDR);
      wire data_wr = IO_WR && (IO_ADDR == DATA_ADDR);
      wire data_rd = IO_RD && (IO_ADDR == DATA_ADDR);
      wire mode_wr = cmd_wr && (expect_q == `PPU_EXP_NONE) && (IO_WDATA[3:0] == `PPU_CODE_MODE);
      wire [7:0] pin_d = PORT_IN[8*p +: 8];
      wire stb_next = (stb_s2_q == stb_s3_q) ? stb_s3_q : stb_f_q;
      wire stb_rise = ~stb_f_q & stb_next;
      wire is_bit = (mode_q == `PPU_MODE_BIT);
      wire is_in = (mode_q == `PPU_MODE_IN);
      wire is_drv = (mode_q == `PPU_MODE_OUT) || (mode_q == `PPU_MODE_BIDIR);
      wire full = (cnt_q == FULL_CNT);
      wire empty = (cnt_q == {(BUF_AW+1){1'b0}});
      wire [7:0] head = fmem[rp_q];
      // strobe end is a finished transfer
      wire push = is_in ? (stb_rise && !full) : (is_drv && data_wr && !full);
      wire pop = is_in ? (data_rd && !empty) : (is_drv && stb_rise && !empty);
      wire [7:0] watched = dir_q & ~mask_q;
      wire [7:0] hit = ~(pin_f_q ^ {8{lvl_q}}) & watched;
      wire cond = andf_q ? ((hit == watched) && (watched != 8'h00)) : (hit != 8'h00);

      ////////////////////////////////////////////////////////////////////////
      // Pin synchronisers; a change counts once stages two and three agree

      always @(posedge CLOCK) begin
        if (SYS_RST) begin
          pin_s1_q <= 8'h00;
          pin_s2_q <= 8'h00;
          pin_s3_q <= 8'h00;
          pin_f_q <= 8'h00;
          stb_s1_q <= 1'b1;
          stb_s2_q <= 1'b1;
          stb_s3_q <= 1'b1;
          stb_f_q <= 1'b1;
        end else begin
          pin_s1_q <= pin_d;
          pin_s2_q <= pin_s1_q;
          pin_s3_q <= pin_s2_q;
          pin_f_q <= (pin_s3_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
          stb_s1_q <= PERIPHERAL_STROBE_IN_N[p];
          stb_s2_q <= stb_s1_q;
          stb_s3_q <= stb_s2_q;
          stb_f_q <= stb_next;
        end
      end

      ////////////////////////////////////////////////////////////////////////
      // Command word sequencer

      always @(posedge CLOCK) begin
        if (SYS_RST) begin
          mode_q <= `PPU_RST_MODE;
          dir_q <= `PPU_RST_BYTE;
          mask_q <= `PPU_RST_BYTE;
          vec_q <= `PPU_RST_VEC;
          expect_q <= `PPU_EXP_NONE;
          ie_q <= 1'b0;
          andf_q <= 1'b0;
          lvl_q <= 1'b0;
        end else if (cmd_wr) begin
          case (expect_q)
            `PPU_EXP_DIR: begin
              dir_q <= IO_WDATA;
              expect_q <= `PPU_EXP_NONE;
            end
            `PPU_EXP_MASK: begin
              mask_q <= IO_WDATA;
              expect_q <= `PPU_EXP_NONE;
            end
            default: begin
              if (IO_WDATA[3:0] == `PPU_CODE_MODE) begin
                mode_q <= IO_WDATA[7:6];
                expect_q <= (IO_WDATA[7:6] == `PPU_MODE_BIT) ? `PPU_EXP_DIR : `PPU_EXP_NONE;
              end else if (IO_WDATA[3:2] == `PPU_CODE_ICTL) begin
                ie_q <= IO_WDATA[`PPU_BIT_ENA];
                andf_q <= IO_WDATA[`PPU_BIT_ANDF];
                lvl_q <= IO_WDATA[`PPU_BIT_LVL];
                expect_q <= IO_WDATA[`PPU_BIT_MASKF] ? `PPU_EXP_MASK : `PPU_EXP_NONE;
              end else if (IO_WDATA[3:0] == `PPU_CODE_DIS) begin
                ie_q <= IO_WDATA[`PPU_BIT_ENA];
              end else if (!IO_WDATA[0]) begin
                vec_q <= IO_WDATA;
              end
            end
          endcase
        end
      end

      ////////////////////////////////////////////////////////////////////////
      // DEPTH-entry buffer (1 << BUF_AW, two at BUF_AW=1); a full buffer drops READY or IO_WR_READY, and a word that arrives while full is discarded

      always @(posedge CLOCK) begin
        if (SYS_RST || mode_wr) begin
          wp_q <= {BUF_AW{1'b0}};
          rp_q <= {BUF_AW{1'b0}};
          cnt_q <= {(BUF_AW+1){1'b0}};
        end else begin
          if (push) begin
            wp_q <= wp_q + 1'b1;
          end
          if (pop) begin
            rp_q <= rp_q + 1'b1;
          end
          cnt_q <= cnt_q + {{BUF_AW{1'b0}}, push} - {{BUF_AW{1'b0}}, pop};
        end
      end

      always @(posedge CLOCK) begin
        if (push) begin
          fmem[wp_q] <= is_in ? pin_f_q : IO_WDATA;
        end
      end

      always @(posedge CLOCK) begin
        if (SYS_RST) begin
          out_q <= 8'h00;
        end else if (data_wr && is_bit) begin
          out_q <= IO_WDATA;
        end
      end

      ////////////////////////////////////////////////////////////////////////
      // Interrupt request; a strobe in the acknowledge cycle wins over the clear

      always @(posedge CLOCK) begin
        if (SYS_RST) begin
          pend_q <= 1'b0;
        end else if (stb_rise && !is_bit) begin
          pend_q <= 1'b1;
        end else if (ack_p[p] || mode_wr) begin
          pend_q <= 1'b0;
        end
      end

      assign INT_REQ[p] = ie_q & (is_bit ? cond : pend_q);
      assign vec_all[8*p +: 8] = vec_q;

      ////////////////////////////////////////////////////////////////////////
      // Pins and host view

      assign READY[p] = is_in ? !full : (is_drv && !empty);
      assign wr_ready[p] = !(is_drv && full);
      assign PORT_OUT[8*p +: 8] = is_bit ? out_q : head;
      assign PORT_OE_N[8*p +: 8] = is_bit ? dir_q :
                                   (mode_q == `PPU_MODE_OUT) ? 8'h00 :
                                   (mode_q == `PPU_MODE_BIDIR && !stb_f_q) ? 8'h00 : 8'hff;
      assign rd_val[8*p +: 8] = is_bit ? ((pin_f_q & dir_q) | (out_q & ~dir_q)) :
                                (mode_q == `PPU_MODE_BIDIR) ? pin_f_q : head;
    end
  endgenerate

endmodule // ppu_top

`default_nettype wire

//--- verif/ppu_periph.sv
`timescale 1ns/1ps
`default_nettype none
module ppu_periph (
  input wire logic clock,
  input wire logic [1:0] ready,
  output logic [15:0] pins,
  output logic [1:0] strobe_n
);
  initial begin
    pins = 16'h0000;
    strobe_n = 2'h3;
  end
  task automatic xfer(input int p, input logic [7:0] d);
    @(posedge clock);
    for (int i = 0; i < 200 && !ready[p]; i++) @(posedge clock);
    pins[p*8 +: 8] <= d;
    repeat (4) @(posedge clock);
    strobe_n[p] <= 1'b0;
    repeat (4) @(posedge clock);
    strobe_n[p] <= 1'b1;
    repeat (4) @(posedge clock);
    // Released lines must not keep showing the old byte
    pins[p*8 +: 8] <= ~d;
  endtask
  task automatic level(input logic [7:0] d);
    @(posedge clock);
    pins[7:0] <= d;
  endtask
endmodule // ppu_periph
`default_nettype wire

//--- verif/ppu_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module ppu_top_props (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [7:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_RDATA,
  input wire logic IO_WR_READY,
  input wire logic [1:0] INT_REQ,
  input wire logic INT_ACK,
  input wire logic [7:0] INT_VECTOR,
  input wire logic [15:0] PORT_OE_N,
  input wire logic [1:0] READY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  wire logic cmd_a;
  assign cmd_a = IO_WR && IO_ADDR == 8'h1d;
  ////////////////////////////////////////////////////////////////////////////////
  property p_rd_zero; IO_RD && IO_ADDR != 8'h1c && IO_ADDR != 8'h1e |=> IO_RDATA == 8'h00; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read not zero");
  property p_rd_hold; !IO_RD |=> $stable(IO_RDATA); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_vec_hold; !INT_ACK |=> $stable(INT_VECTOR); endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
  property p_bit_ready; cmd_a && IO_WDATA[3:0] == 4'hf && IO_WDATA[7:6] == 2'h3 |=> (READY[0] == 1'b0) [*2]; endproperty
  a_bit_ready: assert property (p_bit_ready) else $error("ready in bit mode");
  // Direction byte lands on the pin enables one cycle after it is taken
  property p_dir; cmd_a && IO_WDATA == 8'hcf ##1 !IO_WR ##1 cmd_a |=> PORT_OE_N[7:0] == $past(IO_WDATA); endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_in_mode; cmd_a && IO_WDATA[3:0] == 4'hf && IO_WDATA[7:6] == 2'h1 |=> PORT_OE_N[7:0] == 8'hff && READY[0]; endproperty
  a_in_mode: assert property (p_in_mode) else $error("input mode wrong");
  property p_b_iso; IO_WR && IO_ADDR == 8'h1f |=> $stable(PORT_OE_N[7:0]); endproperty
  a_b_iso: assert property (p_b_iso) else $error("port B write hit port A");
  property p_wr_ready; !IO_WR_READY |-> IO_ADDR == 8'h1c || IO_ADDR == 8'h1e; endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("refusal off data address");
  c_rd_data: cover property (IO_RD && IO_ADDR == 8'h1c);
  c_ack: cover property (INT_ACK && INT_REQ[0]);
  c_full: cover property (!IO_WR_READY);
endmodule // ppu_top_props
bind ppu_top ppu_top_props ppu_top_props_i (.CLOCK, .SYS_RST, .IO_ADDR, .IO_WDATA, .IO_WR, .IO_RD, .IO_RDATA,
  .IO_WR_READY, .INT_REQ, .INT_ACK, .INT_VECTOR, .PORT_OE_N, .READY);
`default_nettype wire

//--- verif/ppu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ppu_top_tb;
  logic CLOCK, SYS_RST, IO_WR, IO_RD, INT_ACK;
  logic [7:0] IO_ADDR, IO_WDATA;
  wire [7:0] IO_RDATA, INT_VECTOR;
  wire [1:0] INT_REQ, READY, strobe_n;
  wire [15:0] port_in, PORT_OUT, PORT_OE_N;
  wire IO_WR_READY;
  int failures, checked, cycles;
  logic [7:0] ua [6] = '{8'h00, 8'h1d, 8'h1f, 8'h20, 8'h9c, 8'hff};
  logic [7:0] cm [9] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h83, 8'h85, 8'h00, 8'h87, 8'h00};
  logic [7:0] pv [9] = '{8'h00, 8'h10, 8'hc0, 8'h10, 8'h10, 8'h10, 8'h00, 8'h30, 8'h10};
  logic [8:0] iv = 9'b011010010;
  ppu_top #(.BUF_AW(1)) ppu_top_i (.CLOCK, .SYS_RST, .IO_ADDR, .IO_WDATA, .IO_WR, .IO_RD, .IO_RDATA,
    .IO_WR_READY, .INT_REQ, .INT_ACK, .INT_VECTOR, .PORT_IN(port_in), .PORT_OUT, .PORT_OE_N, .READY,
    .PERIPHERAL_STROBE_IN_N(strobe_n));
  ppu_periph ppu_periph_i (.clock(CLOCK), .ready(READY), .pins(port_in), .strobe_n);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    IO_ADDR <= a;
    IO_WDATA <= d;
    IO_WR <= 1'b1;
    @(posedge CLOCK);
    IO_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLOCK);
    IO_ADDR <= a;
    IO_RD <= 1'b1;
    @(posedge CLOCK);
    IO_RD <= 1'b0;
    #1;
    chk(IO_RDATA, exp);
  endtask
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    {SYS_RST, IO_WR, IO_RD, INT_ACK} = 4'h8;
    IO_ADDR = 8'h00;
    IO_WDATA = 8'h00;
    repeat (4) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    repeat (3) @(posedge CLOCK);
    foreach (ua[i]) rd(ua[i], 8'h00);
    wr(8'h1d, 8'h4f);
    wr(8'h1d, 8'h10);
    wr(8'h1d, 8'h87);
    ppu_periph_i.xfer(0, 8'h5a);
    repeat (4) @(posedge CLOCK);
    chk(8'(INT_REQ[0]), 8'h01);
    ppu_periph_i.xfer(0, 8'ha5);
    repeat (4) @(posedge CLOCK);
    chk(8'(READY[0]), 8'h00);
    @(posedge CLOCK);
    INT_ACK <= 1'b1;
    @(posedge CLOCK);
    INT_ACK <= 1'b0;
    #1;
    chk(INT_VECTOR, 8'h10);
    chk(8'(INT_REQ[0]), 8'h00);
    rd(8'h1c, 8'h5a);
    rd(8'h1c, 8'ha5);
    chk(8'(READY[0]), 8'h01);
    wr(8'h1d, 8'hcf);
    wr(8'h1d, 8'hf0);
    wr(8'h1c, 8'h0a);
    #1;
    chk(PORT_OE_N[7:0], 8'hf0);
    chk(PORT_OUT[7:0], 8'h0a);
    chk(8'(READY[0]), 8'h00);
    wr(8'h1d, 8'h96);
    wr(8'h1d, 8'hc0);
    for (int i = 0; i < 9; i++) begin
      if (cm[i] != 8'h00) wr(8'h1d, cm[i]);
      ppu_periph_i.level(pv[i]);
      repeat (6) @(posedge CLOCK);
      chk(8'(INT_REQ[0]), 8'(iv[i]));
    end
    wr(8'h1f, 8'h0f);
    wr(8'h1e, 8'h3c);
    wr(8'h1e, 8'hc3);
    #1;
    chk(8'(IO_WR_READY), 8'h00);
    chk(PORT_OUT[15:8], 8'h3c);
    wr(8'h1e, 8'h77);
    ppu_periph_i.xfer(1, 8'h00);
    repeat (4) @(posedge CLOCK);
    chk(PORT_OUT[15:8], 8'hc3);
    ppu_periph_i.xfer(1, 8'h00);
    repeat (4) @(posedge CLOCK);
    chk(8'(READY[1]), 8'h00);
    print_verdict();
  end
endmodule // ppu_top_tb
`default_nettype wire
